// [hdl/isf_status_hold.sv]
// status, FIFO level, SDA hold and abort-cause registers behind an AHB-Lite slave
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module isf_status_hold #(
  parameter int unsigned FIFO_DEPTH = isf_pkg::ISF_FIFO_DEPTH  // entries per FIFO, at most 15
) (
  input  wire logic        hclk,            // system clock, 20 MHz
  input  wire logic        hresetn,         // async reset, active low
  input  wire logic        hsel,            // slave select
  input  wire logic [31:0] haddr,           // byte address
  input  wire logic [1:0]  htrans,          // transfer type
  input  wire logic        hwrite,          // write when high
  input  wire logic [2:0]  hsize,           // transfer size
  input  wire logic        hready,          // bus ready in
  input  wire logic [31:0] hwdata,          // write data
  output logic      [31:0] hrdata,          // read data
  output logic             hreadyout,       // slave ready
  output logic             hresp,           // always okay
  input  wire logic        tx_push,         // entry written into transmit FIFO
  input  wire logic        tx_pop,          // entry taken from transmit FIFO
  input  wire logic        rx_push,         // entry written into receive FIFO
  input  wire logic        rx_pop,          // entry taken from receive FIFO
  input  wire logic        master_fsm_busy, // master machine not idle
  input  wire logic        slave_fsm_busy,  // slave machine not idle
  input  wire logic        addr7_nack_evt,  // 7-bit address not acknowledged
  input  wire logic        arb_lost_evt,    // master lost arbitration
  input  wire logic        slv_arb_lost_evt,// slave transmitter lost arbitration
  input  wire logic        tx_drive,        // engine wants to drive SDA
  input  wire logic        tx_bit,          // next SDA bit from engine
  input  wire logic        scl_i,           // SCL pin level
  input  wire logic        sda_i,           // SDA pin level
  output logic             sda_o,           // SDA drive value
  output logic             sda_oe,          // SDA drive enable, high drives
  output logic             rx_sda,          // held SDA sample for receiver
  output logic             controller_enable// enable bit to the engine
);
  import isf_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [2:0]  scl_sync;
    logic [2:0]  sda_sync;
    logic        scl_st;
    logic        sda_st;
    logic        enable;
    logic        off_by_write;
    logic [15:0] tx_hold;
    logic [7:0]  rx_hold;
    logic [3:0]  tx_cnt;
    logic [3:0]  rx_cnt;
    logic        ab_nack;
    logic        ab_arb;
    logic        ab_slv;
    logic        mbusy;
    logic        sbusy;
    logic [15:0] txh_cnt;
    logic [7:0]  rxh_cnt;
    logic        sda_o;
    logic        sda_oe;
    logic        rx_sda;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] wr_mask;
    logic [31:0] rdata;
    logic        ready;
  } isf_state_t;

  localparam isf_state_t ISF_STATE_RST = '{
    scl_sync: 3'h7, sda_sync: 3'h7, scl_st: 1'b1, sda_st: 1'b1,
    enable: ISF_EN_RST, off_by_write: 1'b0,
    tx_hold: ISF_TRANSMIT_SDA_HOLD_RST, rx_hold: ISF_RECEIVE_SDA_HOLD_RST,
    tx_cnt: 4'h0, rx_cnt: 4'h0, ab_nack: 1'b0, ab_arb: 1'b0, ab_slv: 1'b0,
    mbusy: 1'b0, sbusy: 1'b0, txh_cnt: 16'h0000, rxh_cnt: 8'h00,
    sda_o: 1'b1, sda_oe: 1'b0, rx_sda: 1'b1, wr_pend: 1'b0,
    wr_addr: 8'h00, wr_mask: 32'h0000_0000, rdata: 32'h0000_0000, ready: 1'b1
  };

  localparam logic [3:0] DEPTH_C = 4'(FIFO_DEPTH);

  isf_state_t s_q;
  isf_state_t s_d;

  // ==========================================================
  // helpers
  function automatic logic [31:0] isf_lane_mask(input logic [2:0] size,
                                                input logic [1:0] lo);
    logic [31:0] m;
    m = 32'h0000_0000;
    case (size)
      3'h0:    m = 32'h0000_00FF << {lo, 3'h0};
      3'h1:    m = lo[1] ? 32'hFFFF_0000 : 32'h0000_FFFF;
      default: m = 32'hFFFF_FFFF;
    endcase
    return m;
  endfunction

  // level counter with push/pop, saturating at the FIFO depth
  function automatic logic [3:0] isf_count(input logic [3:0] c, input logic push,
                                           input logic pop, input logic [3:0] depth);
    logic do_push;
    logic do_pop;
    do_push = push && (c != depth);
    do_pop  = pop && (c != 4'h0);
    if (do_push && !do_pop) begin
      return c + 4'h1;
    end else if (do_pop && !do_push) begin
      return c - 4'h1;
    end
    return c;
  endfunction

  // status word from one state copy
  function automatic logic [31:0] isf_status(input isf_state_t s, input logic [3:0] depth);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[ISF_ST_ACTIVE]    = s.mbusy || s.sbusy;
    v[ISF_ST_TX_NFULL]  = (s.tx_cnt != depth) && !s.off_by_write;
    v[ISF_ST_TX_EMPTY]  = (s.tx_cnt == 4'h0) && !s.off_by_write;
    v[ISF_ST_RX_NEMPTY] = (s.rx_cnt != 4'h0) && !s.off_by_write;
    v[ISF_ST_RX_FULL]   = (s.rx_cnt == depth);
    v[ISF_ST_MBUSY]     = s.mbusy;
    v[ISF_ST_SBUSY]     = s.sbusy;
    return v;
  endfunction

  // ==========================================================
  // next state
  logic        acc;
  logic        scl_fall;
  logic [31:0] wdat;
  logic [31:0] hold_word;

  always_comb begin
    s_d       = s_q;
    acc       = hsel && hready && (htrans == ISF_HTRANS_NONSEQ || htrans == 2'h3);
    wdat      = hwdata & s_q.wr_mask;
    hold_word = 32'h0000_0000;

    // pins: three flops, a change counts once the last two agree
    s_d.scl_sync = {s_q.scl_sync[1:0], scl_i};
    s_d.sda_sync = {s_q.sda_sync[1:0], sda_i};
    if (s_q.scl_sync[1] == s_q.scl_sync[2]) begin
      s_d.scl_st = s_q.scl_sync[2];
    end
    if (s_q.sda_sync[1] == s_q.sda_sync[2]) begin
      s_d.sda_st = s_q.sda_sync[2];
    end
    scl_fall = s_q.scl_st && !s_d.scl_st;

    // write data phase; read-only and unmapped addresses fall through
    // only enable and hold take writes
    if (s_q.wr_pend) begin
      case (s_q.wr_addr)
        ISF_ENABLE_CTRL_ADDR: begin
          if (s_q.wr_mask[ISF_EN_BIT]) begin
            if (s_q.enable && !hwdata[ISF_EN_BIT]) begin
              s_d.off_by_write = 1'b1;
            end
            if (hwdata[ISF_EN_BIT]) begin
              s_d.off_by_write = 1'b0;
            end
            s_d.enable = hwdata[ISF_EN_BIT];
          end
        end
        ISF_HOLD_ADDR: begin
          s_d.tx_hold = (s_q.tx_hold & ~s_q.wr_mask[15:0]) | wdat[15:0];
          s_d.rx_hold = (s_q.rx_hold & ~s_q.wr_mask[23:16]) | wdat[23:16];
        end
        default: begin
        end
      endcase
    end

    // engine state, registered once
    // busy follows the machines, so idle reads zero
    s_d.mbusy = master_fsm_busy;
    s_d.sbusy = slave_fsm_busy;

    // disabled controller keeps both FIFOs flushed
    if (!s_d.enable) begin
      s_d.tx_cnt = 4'h0;
      s_d.rx_cnt = 4'h0;
    end else begin
      s_d.tx_cnt = isf_count(s_q.tx_cnt, tx_push, tx_pop, DEPTH_C);
      s_d.rx_cnt = isf_count(s_q.rx_cnt, rx_push, rx_pop, DEPTH_C);
    end

    // abort causes: sticky, cleared on re-enable, recorded only while enabled
    if (s_q.wr_pend && s_q.wr_addr == ISF_ENABLE_CTRL_ADDR && s_d.enable && !s_q.enable) begin
      s_d.ab_nack = 1'b0;
      s_d.ab_arb  = 1'b0;
      s_d.ab_slv  = 1'b0;
    end
    if (s_q.enable) begin
      if (addr7_nack_evt) begin
        s_d.ab_nack = 1'b1;
      end
      if (arb_lost_evt || slv_arb_lost_evt) begin
        s_d.ab_arb = 1'b1;
      end
      if (slv_arb_lost_evt) begin
        s_d.ab_slv = 1'b1;
      end
    end

    // transmit hold after each SCL fall
    if (scl_fall) begin
      s_d.txh_cnt = s_q.tx_hold;
    end else if (s_q.txh_cnt != 16'h0000) begin
      s_d.txh_cnt = s_q.txh_cnt - 16'h0001;
    end
    s_d.sda_oe = s_q.enable && tx_drive;
    if (!s_d.sda_oe) begin
      s_d.sda_o = 1'b1;
    end else if (!scl_fall && s_q.txh_cnt == 16'h0000) begin
      s_d.sda_o = tx_bit;
    end

    // receive hold after each SCL fall
    if (scl_fall) begin
      s_d.rxh_cnt = s_q.rx_hold;
    end else if (s_q.rxh_cnt != 8'h00) begin
      s_d.rxh_cnt = s_q.rxh_cnt - 8'h01;
    end
    if (!scl_fall && s_q.rxh_cnt == 8'h00) begin
      s_d.rx_sda = s_q.sda_st;
    end

    // address phase; read data from the updated copy so a read right
    // after a write returns the new value without a wait state
    s_d.wr_pend = acc && hwrite;
    s_d.wr_addr = haddr[7:0];
    s_d.wr_mask = isf_lane_mask(hsize, haddr[1:0]);
    s_d.ready   = 1'b1;
    hold_word[ISF_TRANSMIT_SDA_HOLD_LSB +: 16] = s_d.tx_hold;
    hold_word[ISF_RECEIVE_SDA_HOLD_LSB +: 8]  = s_d.rx_hold;
    if (acc && !hwrite) begin
      if (haddr[31:8] != 24'h00_0000) begin
        s_d.rdata = 32'h0000_0000;
      end else begin
        case (haddr[7:0])
          ISF_ENABLE_CTRL_ADDR: s_d.rdata = {31'h0, s_d.enable};
          ISF_STATUS_ADDR:      s_d.rdata = isf_status(s_d, DEPTH_C);
          ISF_TX_LEVEL_ADDR:    s_d.rdata = {28'h0, s_d.tx_cnt};
          ISF_RX_LEVEL_ADDR:    s_d.rdata = {28'h0, s_d.rx_cnt};
          ISF_HOLD_ADDR:        s_d.rdata = hold_word;
          ISF_ABORT_ADDR:       s_d.rdata = {17'h0, s_d.ab_slv, 3'h0, s_d.ab_arb,
                                             9'h0, s_d.ab_nack};
          default:              s_d.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= ISF_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign hrdata            = s_q.rdata;
  assign hreadyout         = s_q.ready;
  assign hresp             = 1'b0;
  assign sda_o             = s_q.sda_o;
  assign sda_oe            = s_q.sda_oe;
  assign rx_sda            = s_q.rx_sda;
  assign controller_enable = s_q.enable;

  // ==========================================================
  // checks
  logic [31:0] st_now;
  logic        rd_status;
  logic        rd_txlvl;
  logic        first_q;
  assign st_now = isf_status(s_q, DEPTH_C);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_status <= 1'b0;
      rd_txlvl  <= 1'b0;
      first_q   <= 1'b1;
    end else begin
      rd_status <= acc && !hwrite && haddr == {24'h0, ISF_STATUS_ADDR};
      rd_txlvl  <= acc && !hwrite && haddr == {24'h0, ISF_TX_LEVEL_ADDR};
      first_q   <= 1'b0;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_reset_status: assert property (first_q |-> st_now == ISF_STATUS_RST)
    else $error("status after reset is not 0x06");
  chk_status_read: assert property (rd_status |-> hrdata[31:7] == 25'h0)
    else $error("status reserved bits not zero");
  chk_active_flag: assert property (st_now[ISF_ST_ACTIVE] == (s_q.mbusy || s_q.sbusy))
    else $error("activity flag wrong");
  chk_tx_full: assert property (s_q.tx_cnt == DEPTH_C |-> !st_now[ISF_ST_TX_NFULL])
    else $error("not-full set while full");
  chk_tx_empty: assert property ((!s_q.off_by_write && s_q.tx_cnt == 4'h0)
                                 |-> st_now[ISF_ST_TX_EMPTY])
    else $error("empty flag missing");
  chk_off_forces: assert property (s_q.off_by_write |-> st_now[3:1] == 3'h0)
    else $error("flags not forced low after disable");
  chk_flush_off: assert property (!s_q.enable |-> s_q.tx_cnt == 4'h0 && s_q.rx_cnt == 4'h0)
    else $error("FIFO not flushed while disabled");
  chk_level_read: assert property (rd_txlvl |-> hrdata == {28'h0, s_q.tx_cnt})
    else $error("transmit level read mismatch");
  chk_tx_hold: assert property (s_q.txh_cnt != 16'h0 && s_q.sda_oe && s_q.enable && tx_drive
                                |=> $stable(s_q.sda_o))
    else $error("SDA changed inside transmit hold");
  chk_rx_hold: assert property (s_q.rxh_cnt != 8'h0 |=> $stable(s_q.rx_sda))
    else $error("receive sample changed inside hold");
  chk_nack_abort: assert property (s_q.enable && addr7_nack_evt |=> s_q.ab_nack)
    else $error("address nack abort not recorded");
  chk_arb_abort: assert property (s_q.enable && slv_arb_lost_evt |=> s_q.ab_arb && s_q.ab_slv)
    else $error("slave arbitration loss not recorded");

  cov_status_read: cover property (rd_status);
  cov_tx_fill:     cover property (s_q.tx_cnt == DEPTH_C);
  cov_hold_run:    cover property (s_q.txh_cnt != 16'h0 ##1 s_q.txh_cnt == 16'h0);
  cov_disable:     cover property (s_q.enable ##1 s_q.off_by_write);
endmodule
`default_nettype wire

// [inc/isf_pkg.sv]
// constants and register map of the two-wire status, level and hold block
// What this block does
// - transfer status is read-only, side-effect free, and raises no interrupt
// - disabling by writing zero to enable forces status bits 1, 2, 3 low
// - master and slave busy read zero once idle with enable off
// - status bit 0 shows bus activity, zero when idle
// - status bit 1 is one only while the transmit FIFO is not full
// - status bit 2 is one only while the transmit FIFO is empty
// - status bit 3 is one while the receive FIFO holds an entry
// - status bit 4 is one only while the receive FIFO is full
// - status bit 5 is one whenever the master machine is not idle
// - status bit 6 is one whenever the slave machine is not idle
// - status reads 0x06 after reset
// - transmit level bits 3:0 give the transmit FIFO entry count
// - receive level bits 3:0 give the receive FIFO entry count
// - transmit hold bits 15:0 delay SDA change after each SCL fall
// - receive hold bits 23:16 delay SDA sampling after each SCL fall
// - abort bit 0 marks an unacknowledged 7-bit address
// - enable low keeps both FIFOs flushed, enable high runs
// - abort bit 10 marks lost arbitration, with bit 14 for slave transmitter
package isf_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0]  ISF_ENABLE_CTRL_ADDR = 8'h6C;
  localparam logic [7:0]  ISF_STATUS_ADDR      = 8'h70;
  localparam logic [7:0]  ISF_TX_LEVEL_ADDR    = 8'h74;
  localparam logic [7:0]  ISF_RX_LEVEL_ADDR    = 8'h78;
  localparam logic [7:0]  ISF_HOLD_ADDR        = 8'h7C;
  localparam logic [7:0]  ISF_ABORT_ADDR       = 8'h80;
  // ==========================================================
  // field positions
  localparam int          ISF_EN_BIT           = 0;
  localparam int          ISF_ST_ACTIVE        = 0;
  localparam int          ISF_ST_TX_NFULL      = 1;
  localparam int          ISF_ST_TX_EMPTY      = 2;
  localparam int          ISF_ST_RX_NEMPTY     = 3;
  localparam int          ISF_ST_RX_FULL       = 4;
  localparam int          ISF_ST_MBUSY         = 5;
  localparam int          ISF_ST_SBUSY         = 6;
  localparam int          ISF_AB_ADDR7_NACK    = 0;
  localparam int          ISF_AB_ARB_LOST      = 10;
  localparam int          ISF_AB_SLV_ARB       = 14;
  localparam int          ISF_TRANSMIT_SDA_HOLD_LSB       = 0;
  localparam int          ISF_RECEIVE_SDA_HOLD_LSB       = 16;
  // ==========================================================
  // reset values
  localparam logic [31:0] ISF_STATUS_RST       = 32'h0000_0006;
  localparam logic [15:0] ISF_TRANSMIT_SDA_HOLD_RST       = 16'h0001;
  localparam logic [7:0]  ISF_RECEIVE_SDA_HOLD_RST       = 8'h00;
  localparam logic        ISF_EN_RST           = 1'b0;
  // ==========================================================
  // bus encodings
  localparam logic [1:0]  ISF_HTRANS_NONSEQ    = 2'h2;
  localparam int          ISF_FIFO_DEPTH       = 8;
endpackage

// [dv/isf_bus_partner.sv]
// far-side two-wire device: clocks frames on SCL and shares SDA by wired-and
`timescale 1ns/1ps
`default_nettype none
module isf_bus_partner #(
  parameter int HALF_NS = 200,  // half of the 400 ns link period
  parameter int NBITS   = 4     // clock pulses per frame
) (
  input  wire logic start,      // rising edge begins one frame
  input  wire logic sda_o,      // controller SDA value
  input  wire logic sda_oe,     // controller SDA drive enable
  output logic      scl,        // SCL wire level
  output wire logic sda         // SDA wire level
);
  logic drv_low;

  // ==========================================================
  // wire resolution
  // pull-up: a released line reads one, never the last value
  assign sda = ~drv_low & (sda_oe ? sda_o : 1'b1);

  initial begin
    scl     = 1'b1;
    drv_low = 1'b0;
  end

  // ==========================================================
  // frame generator
  // scl stands high between frames, it does not run free
  always @(posedge start) begin
    drv_low = 1'b1;
    #(HALF_NS);
    for (int i = 0; i < NBITS; i++) begin
      scl = 1'b0;
      #(HALF_NS / 2);
      drv_low = i[0];
      #(HALF_NS / 2);
      scl = 1'b1;
      #(HALF_NS);
    end
    drv_low = 1'b0;
  end
endmodule
`default_nettype wire

// [dv/i2c_status_fifo_level_hold_tb.sv]
// self-checking bench for the status, level, abort and SDA hold block
`timescale 1ns/1ps
`default_nettype none
module i2c_status_fifo_level_hold_tb;
  import isf_pkg::*;
  localparam int D = 8;
  logic             hclk, hresetn, hsel, hwrite, tx_drive, tx_bit, mbusy, sbusy, frame;
  logic      [1:0]  htrans;
  logic      [2:0]  hsize;
  logic      [31:0] haddr, hwdata;
  logic      [6:0]  strb;
  int               miscompares, num_checks, r1, r3;
  wire logic [31:0] hrdata;
  wire logic        hreadyout, hresp, sda_o, sda_oe, rx_sda, en, scl, sda;

  isf_status_hold #(.FIFO_DEPTH(D)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tx_push(strb[0]), .tx_pop(strb[1]), .rx_push(strb[2]), .rx_pop(strb[3]),
    .master_fsm_busy(mbusy), .slave_fsm_busy(sbusy), .addr7_nack_evt(strb[4]),
    .arb_lost_evt(strb[5]), .slv_arb_lost_evt(strb[6]), .tx_drive(tx_drive),
    .tx_bit(tx_bit), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .rx_sda(rx_sda), .controller_enable(en));

  isf_bus_partner partner (.start(frame), .sda_o(sda_o), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  always #25 hclk = ~hclk;

  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one single AHB transfer; read data taken at the data-phase edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= ISF_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask

  // strobes drop for one edge so no pulse merges with the next
  task automatic pulse(input logic [6:0] m);
    strb <= m;
    @(posedge hclk);
    strb <= 7'h00;
    @(posedge hclk);
  endtask

  task automatic st_chk(input int t, input int r);
    logic [31:0] e;
    e = 32'h0;
    e[ISF_ST_ACTIVE]    = mbusy | sbusy;
    e[ISF_ST_TX_NFULL]  = (t != D);
    e[ISF_ST_TX_EMPTY]  = (t == 0);
    e[ISF_ST_RX_NEMPTY] = (r != 0);
    e[ISF_ST_RX_FULL]   = (r == D);
    e[ISF_ST_MBUSY]     = mbusy;
    e[ISF_ST_SBUSY]     = sbusy;
    rd_chk("status", ISF_STATUS_ADDR, e);
    rd_chk("tx_level", ISF_TX_LEVEL_ADDR, 32'(t));
    rd_chk("rx_level", ISF_RX_LEVEL_ADDR, 32'(r));
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd_chk("status", ISF_STATUS_ADDR, 32'h0000_0006);
    rd_chk("status", ISF_STATUS_ADDR, 32'h0000_0006);
    rd_chk("hold", ISF_HOLD_ADDR, 32'h0000_0001);
    rd_chk("abort", ISF_ABORT_ADDR, 32'h0);
    st_chk(0, 0);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("enable", 32'h0, {31'h0, en});
  endtask

  task automatic t_ro;
    logic [7:0] a [6] = '{8'h70, 8'h74, 8'h78, 8'h80, 8'h7C, 8'h90};
    foreach (a[i]) wr(a[i], 32'hFFFF_FFFF);
    st_chk(0, 0);
    rd_chk("abort", ISF_ABORT_ADDR, 32'h0);
    rd_chk("unmapped", 8'h90, 32'h0);
    rd_chk("hold", ISF_HOLD_ADDR, 32'h00FF_FFFF);
    wr(ISF_HOLD_ADDR, 32'h00A5_5A3C);
    rd_chk("hold", ISF_HOLD_ADDR, 32'h00A5_5A3C);
  endtask

  task automatic t_fifo;
    wr(ISF_ENABLE_CTRL_ADDR, 32'h1);
    for (int i = 0; i <= D; i++) begin
      st_chk(i, i);
      pulse(7'h05);
    end
    st_chk(D, D);
    for (int i = D; i > 0; i--) begin
      pulse(7'h02);
      st_chk(i - 1, D);
    end
    for (int i = D; i > 0; i--) begin
      pulse(7'h08);
      st_chk(0, i - 1);
    end
    pulse(7'h0A);
    pulse(7'h01);
    pulse(7'h03);
    st_chk(1, 0);
    pulse(7'h02);
  endtask

  task automatic t_busy;
    mbusy <= 1'b1;
    @(posedge hclk);
    st_chk(0, 0);
    mbusy <= 1'b0;
    sbusy <= 1'b1;
    @(posedge hclk);
    st_chk(0, 0);
    sbusy <= 1'b0;
    @(posedge hclk);
    st_chk(0, 0);
  endtask

  task automatic t_abort;
    pulse(7'h10);
    rd_chk("abort", ISF_ABORT_ADDR, 32'h0000_0001);
    pulse(7'h20);
    rd_chk("abort", ISF_ABORT_ADDR, 32'h0000_0401);
    pulse(7'h40);
    rd_chk("abort", ISF_ABORT_ADDR, 32'h0000_4401);
    wr(ISF_ENABLE_CTRL_ADDR, 32'h0);
    pulse(7'h70);
    wr(ISF_ENABLE_CTRL_ADDR, 32'h1);
    rd_chk("abort", ISF_ABORT_ADDR, 32'h0);
  endtask

  task automatic t_disable;
    tx_drive <= 1'b1;
    pulse(7'h05);
    pulse(7'h05);
    wr(ISF_ENABLE_CTRL_ADDR, 32'h0);
    rd_chk("status", ISF_STATUS_ADDR, 32'h0);
    pulse(7'h05);
    rd_chk("tx_level", ISF_TX_LEVEL_ADDR, 32'h0);
    rd_chk("rx_level", ISF_RX_LEVEL_ADDR, 32'h0);
    rd_chk("status", ISF_STATUS_ADDR, 32'h0);
    chk("sda_oe", 32'h0, {31'h0, sda_oe});
    chk("enable", 32'h0, {31'h0, en});
    chk("rx_sda", 32'h1, {31'h0, rx_sda});
    wr(ISF_ENABLE_CTRL_ADDR, 32'h1);
    st_chk(0, 0);
  endtask

  // longest stretch that sda_o ignores a toggling bit, over one frame
  task automatic t_hold(input logic [15:0] n, output int run);
    int   cur;
    logic prev;
    wr(ISF_HOLD_ADDR, {16'h0, n});
    run   = 0;
    cur   = 0;
    prev  = sda_o;
    frame <= 1'b1;
    repeat (44) begin
      @(posedge hclk);
      tx_bit <= ~tx_bit;
      cur = (sda_o === prev) ? cur + 1 : 0;
      if (cur > run) run = cur;
      prev = sda_o;
    end
    frame <= 1'b0;
    chk("sda_oe", 32'h1, {31'h0, sda_oe});
  endtask

  task automatic test_done;
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0;
    hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0; strb = 7'h00; mbusy = 1'b0;
    sbusy = 1'b0; tx_drive = 1'b0; tx_bit = 1'b0; frame = 1'b0;
    miscompares = 0; num_checks = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_ro;
    t_fifo;
    t_busy;
    t_abort;
    t_disable;
    t_hold(16'h0001, r1);
    t_hold(16'h0003, r3);
    chk("hold span", 32'h2, 32'(r3 - r1));
    test_done;
  end

  initial begin
    #200_000;
    miscompares++;
    test_done;
  end
endmodule
`default_nettype wire
